// file: rnpc_pkg.sv
// Package of constants and types for the reset, NMI and power-down pin control block.
package rnpc_pkg;

   // ****************************************************************
   // Timing figures and derived cycle counts.
   // ****************************************************************
   localparam int CLK_PERIOD_PS     = 20000;   // 50 MHz system clock.
   localparam int SPIKE_REJECT_PS   = 10000;   // Longest pulse that is always rejected.
   localparam int SPIKE_ACCEPT_PS   = 100000;  // Shortest pulse that must pass.
   // Accept count rounds down so that a 100 ns low always passes.
   localparam int FILT_CYCLES = (SPIKE_ACCEPT_PS / CLK_PERIOD_PS) < 1 ? 1 :
                                (SPIKE_ACCEPT_PS / CLK_PERIOD_PS);
   localparam int FILT_CNT_W  = 4;

   // Length of the internal reset sequence in cycles.
   localparam int RST_SEQ_CYCLES = 16;
   localparam int RST_SEQ_W      = 5;

   // Reset-source codes reported on the source flags.
   localparam logic [1:0] SRC_NONE     = 2'h0;
   localparam logic [1:0] SRC_HW_LONG  = 2'h1;
   localparam logic [1:0] SRC_SW       = 2'h2;
   localparam logic [1:0] SRC_WATCHDOG = 2'h3;

   // Reset sequencer states.
   typedef enum logic [1:0] {RNPC_RUN, RNPC_SEQ, RNPC_INIT} rnpc_state_t;

endpackage

// file: rnpc_sync_filter.sv
// Two-flop synchroniser followed by a low-pulse spike filter.
`timescale 1ns/1ps
module rnpc_sync_filter
   import rnpc_pkg::*;
#(
   parameter int CYCLES = FILT_CYCLES
)
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic pin_in,
   output logic      level_out
);

   logic                  sync1_r;
   logic                  sync2_r;
   logic [FILT_CNT_W-1:0] cnt_r;
   logic [FILT_CNT_W-1:0] cnt_nxt;
   logic                  level_r;
   logic                  level_nxt;

   // ****************************************************************
   // Filter: output follows the input only after it has been stable.
   // ****************************************************************

   // Count cycles that the synchronised input differs from the output.
   always_comb
   begin
      cnt_nxt   = '0;
      level_nxt = level_r;
      if (sync2_r != level_r)
      begin
         if (cnt_r >= FILT_CNT_W'(CYCLES - 1))
         begin
            level_nxt = sync2_r;
         end
         else
         begin
            cnt_nxt = cnt_r + 4'h1;
         end
      end
   end

   // Synchroniser and filter state; the line idles high.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
         cnt_r   <= '0;
         level_r <= 1'b1;
      end
      else
      begin
         sync1_r <= pin_in;
         sync2_r <= sync1_r;
         cnt_r   <= cnt_nxt;
         level_r <= level_nxt;
      end
   end

   assign level_out = level_r;

endmodule

// file: rnpc_top.sv
// Reset request, reset indication, NMI trap and power-down gating logic.
// Functional notes
// - Low reset request pin resets the device
// - Reject short low spikes, accept long ones
// - Bidirectional mode drives request line during reset
// - Indication output low during any reset
// - Indication released only by end-of-init instruction
// - Falling NMI edge raises NMI trap; the code ignores edges during the reset sequence (RNPC_SEQ)
// - Power-down entered only with NMI low
// - NMI high: power-down ignored, keep running
// - Enable bit locked after init, reset clears
// - Bidirectional mode reports long hardware reset source
`timescale 1ns/1ps
module rnpc_top
   import rnpc_pkg::*;
#(
   parameter int SEQ_CYCLES = RST_SEQ_CYCLES
)
(
   input  wire logic       CLK_SYS,
   input  wire logic       RESET,
   input  wire logic       RESET_REQUEST_PIN_I,
   output logic            RESET_REQUEST_PIN_O,
   output logic            RESET_REQUEST_PIN_OE,
   output logic            RESET_INDICATION_OUT_N,
   input  wire logic       NMI_PIN,
   input  wire logic       SW_RESET_REQ,
   input  wire logic       WATCHDOG_TIMER_RESET,
   input  wire logic       END_OF_INIT_INSTR,
   input  wire logic       POWER_DOWN_INSTR,
   input  wire logic       BIDIR_RESET_ENABLE_WR,
   input  wire logic       BIDIR_RESET_ENABLE_WDATA,
   output logic            BIDIR_RESET_ENABLE,
   output logic            CORE_RESET,
   output logic            NMI_TRAP,
   output logic            POWER_DOWN,
   output logic [1:0]      RESET_SOURCE
);

   logic        req_level;
   logic        nmi_level;
   logic        nmi_prev_r;
   rnpc_state_t state_r;
   rnpc_state_t state_nxt;
   logic [RST_SEQ_W-1:0] seq_cnt_r;
   logic [RST_SEQ_W-1:0] seq_cnt_nxt;
   logic        bidir_r;
   logic        bidir_nxt;
   logic        reset_indication_out_n_r;
   logic        reset_indication_out_n_nxt;
   logic        drive_r;
   logic        drive_nxt;
   logic [1:0]  src_r;
   logic [1:0]  src_nxt;
   logic        trap_r;
   logic        trap_nxt;
   logic        pdn_r;
   logic        pdn_nxt;
   logic        ext_req;
   logic        int_req;
   logic        echo_r;
   logic        echo_nxt;

   // ****************************************************************
   // Pin conditioning.
   // ****************************************************************

   // Reset request pin is synchronised and spike filtered.
   rnpc_sync_filter #(.CYCLES(FILT_CYCLES)) u_req_filt
   (
      .clk       (CLK_SYS),
      .rst       (RESET),
      .pin_in    (RESET_REQUEST_PIN_I),
      .level_out (req_level)
   );

   // NMI pin is synchronised; one-cycle filter keeps edge detection clean.
   rnpc_sync_filter #(.CYCLES(1)) u_nmi_sync
   (
      .clk       (CLK_SYS),
      .rst       (RESET),
      .pin_in    (NMI_PIN),
      .level_out (nmi_level)
   );

   // While we drive the line ourselves, and until our own low has drained out
   // of the filter, its low level is not a new request.
   assign ext_req = !req_level && !drive_r && !echo_r;
   assign int_req = SW_RESET_REQ || WATCHDOG_TIMER_RESET;

   // ****************************************************************
   // Reset sequencer and indication output.
   // ****************************************************************

   // Next-state logic for sequencing, indication, source and enable bit.
   always_comb
   begin
      state_nxt    = state_r;
      seq_cnt_nxt  = seq_cnt_r;
      bidir_nxt    = bidir_r;
      reset_indication_out_n_nxt = reset_indication_out_n_r;
      drive_nxt    = drive_r;
      src_nxt      = src_r;
      // Masks the filtered echo of our own drive after the line is released.
      echo_nxt     = drive_r || (echo_r && !req_level);
      if (ext_req || int_req)
      begin
         state_nxt    = RNPC_SEQ;
         seq_cnt_nxt  = '0;
         reset_indication_out_n_nxt = 1'b0;
         drive_nxt    = bidir_r;
         bidir_nxt    = 1'b0;
         if (bidir_r || ext_req)
         begin
            src_nxt = SRC_HW_LONG;
         end
         else if (WATCHDOG_TIMER_RESET)
         begin
            src_nxt = SRC_WATCHDOG;
         end
         else
         begin
            src_nxt = SRC_SW;
         end
      end
      else
      begin
         unique case (state_r)
            RNPC_SEQ:
            begin
               // Sequence ends once the count runs out.
               if (seq_cnt_r >= RST_SEQ_W'(SEQ_CYCLES - 1))
               begin
                  state_nxt = RNPC_INIT;
                  drive_nxt = 1'b0;
               end
               else
               begin
                  seq_cnt_nxt = seq_cnt_r + 5'h01;
               end
            end
            RNPC_INIT:
            begin
               // Enable bit writable only before end of initialisation.
               if (BIDIR_RESET_ENABLE_WR)
               begin
                  bidir_nxt = BIDIR_RESET_ENABLE_WDATA;
               end
               if (END_OF_INIT_INSTR)
               begin
                  state_nxt    = RNPC_RUN;
                  reset_indication_out_n_nxt = 1'b1;
               end
            end
            RNPC_RUN:
            begin
               state_nxt = RNPC_RUN;
            end
         endcase
      end
   end

   // Sequencer registers; reset leaves the device in a fresh sequence.
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
      begin
         state_r    <= RNPC_SEQ;
         seq_cnt_r  <= '0;
         bidir_r    <= 1'b0;
         reset_indication_out_n_r <= 1'b0;
         drive_r    <= 1'b0;
         src_r      <= SRC_HW_LONG;
         echo_r     <= 1'b0;
      end
      else
      begin
         echo_r     <= echo_nxt;
         state_r    <= state_nxt;
         seq_cnt_r  <= seq_cnt_nxt;
         bidir_r    <= bidir_nxt;
         reset_indication_out_n_r <= reset_indication_out_n_nxt;
         drive_r    <= drive_nxt;
         src_r      <= src_nxt;
      end
   end

   // ****************************************************************
   // NMI trap and power-down gating.
   // ****************************************************************

   // Trap pulses on a falling NMI edge in RNPC_INIT or RNPC_RUN; power-down only with NMI low.
   always_comb
   begin
      trap_nxt = (state_r == RNPC_RUN || state_r == RNPC_INIT)
                 && nmi_prev_r && !nmi_level;
      pdn_nxt  = pdn_r;
      if (POWER_DOWN_INSTR && state_r == RNPC_RUN)
      begin
         pdn_nxt = !nmi_level;
      end
      if (ext_req || int_req || state_r != RNPC_RUN)
      begin
         pdn_nxt = 1'b0;
      end
   end

   // NMI edge and power-down registers.
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
      begin
         nmi_prev_r <= 1'b1;
         trap_r     <= 1'b0;
         pdn_r      <= 1'b0;
      end
      else
      begin
         nmi_prev_r <= nmi_level;
         trap_r     <= trap_nxt;
         pdn_r      <= pdn_nxt;
      end
   end

   // ****************************************************************
   // Outputs.
   // ****************************************************************

   // The request line is open drain: drive low only while enabled.
   assign RESET_REQUEST_PIN_O    = 1'b0;
   assign RESET_REQUEST_PIN_OE   = drive_r;
   assign RESET_INDICATION_OUT_N = reset_indication_out_n_r;
   assign BIDIR_RESET_ENABLE     = bidir_r;
   assign CORE_RESET             = (state_r == RNPC_SEQ);
   assign NMI_TRAP               = trap_r;
   assign POWER_DOWN             = pdn_r;
   assign RESET_SOURCE           = src_r;

endmodule

// file: rnpc_assertions.sv
// Concurrent checks on the reset, NMI and power-down pins of the block.
`timescale 1ns/1ps
module rnpc_assertions
   import rnpc_pkg::*;
#(
   parameter int SEQ_CYCLES = RST_SEQ_CYCLES
)
(
   input wire logic       CLK_SYS,
   input wire logic       RESET,
   input wire logic       RESET_REQUEST_PIN_I,
   input wire logic       RESET_REQUEST_PIN_O,
   input wire logic       RESET_REQUEST_PIN_OE,
   input wire logic       RESET_INDICATION_OUT_N,
   input wire logic       NMI_PIN,
   input wire logic       SW_RESET_REQ,
   input wire logic       WATCHDOG_TIMER_RESET,
   input wire logic       END_OF_INIT_INSTR,
   input wire logic       POWER_DOWN_INSTR,
   input wire logic       BIDIR_RESET_ENABLE_WR,
   input wire logic       BIDIR_RESET_ENABLE_WDATA,
   input wire logic       BIDIR_RESET_ENABLE,
   input wire logic       CORE_RESET,
   input wire logic       NMI_TRAP,
   input wire logic       POWER_DOWN,
   input wire logic [1:0] RESET_SOURCE
);
   logic [7:0] run_r;
   logic [7:0] run_nxt;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET);
   // Counts how long the internal reset has been standing.
   // Saturates so that a long held request cannot wrap it.
   always_comb run_nxt = (RESET || !CORE_RESET) ? 8'h00 :
                         (run_r == 8'hff) ? run_r : run_r + 8'h01;
   always_ff @(posedge CLK_SYS) run_r <= run_nxt;
   // Pin levels held long enough to pass the synchroniser and filter.
   sequence nmi_low_s; !NMI_PIN [*5]; endsequence
   sequence nmi_high_s; NMI_PIN [*5]; endsequence
   sequence pd_req_s; POWER_DOWN_INSTR && RESET_INDICATION_OUT_N && !SW_RESET_REQ
      && !WATCHDOG_TIMER_RESET; endsequence
   seq_len_a:
      assert property ($fell(CORE_RESET) |-> run_r >= SEQ_CYCLES) else $error("reset too short");
   ind_low_a:
      assert property (CORE_RESET |-> !RESET_INDICATION_OUT_N) else $error("indication high");
   ind_rel_a:
      assert property ($rose(RESET_INDICATION_OUT_N) |-> $past(END_OF_INIT_INSTR)
         || $past(END_OF_INIT_INSTR, 2)) else $error("indication released early");
   oe_core_a:
      assert property (RESET_REQUEST_PIN_OE |-> CORE_RESET && !RESET_REQUEST_PIN_O)
         else $error("line driven outside reset");
   trap_pulse_a:
      assert property (NMI_TRAP |-> !$past(NMI_PIN, 2) ##1 !NMI_TRAP) else $error("bad trap");
   pd_enter_a:
      assert property (nmi_low_s ##0 pd_req_s |=> POWER_DOWN) else $error("no power-down");
   pd_ignore_a:
      assert property (nmi_high_s ##0 pd_req_s ##0 !POWER_DOWN |=> !POWER_DOWN)
         else $error("power-down with pin high");
   bit_lock_a:
      assert property (RESET_INDICATION_OUT_N && BIDIR_RESET_ENABLE_WR && !SW_RESET_REQ
         && !WATCHDOG_TIMER_RESET |=> $stable(BIDIR_RESET_ENABLE)) else $error("bit written");
   src_bidir_a:
      assert property ($rose(CORE_RESET) && $past(BIDIR_RESET_ENABLE) |->
         RESET_SOURCE == SRC_HW_LONG) else $error("source not long reset");
endmodule
bind rnpc_top rnpc_assertions #(.SEQ_CYCLES(SEQ_CYCLES)) u_rnpc_assertions (.*);

// file: rnpc_board.sv
// Board-side model: reset source with pull-up and the NMI driver.
`timescale 1ns/1ps
module rnpc_board
(
   input  wire logic dev_oe,
   input  wire logic dev_o,
   output logic      pad,
   output logic      nmi_pad
);
   logic pull_low = 1'b0;
   // Open-drain line with pull-up: low while either party pulls it.
   assign pad = ((dev_oe && !dev_o) || pull_low) ? 1'b0 : 1'b1;
   // NMI line idles high through its external pull-up.
   initial nmi_pad = 1'b1;
   // Pulls the request line low for the given number of ns.
   task automatic hold_low(input int ns);
      pull_low = 1'b1;
      #(ns);
      pull_low = 1'b0;
   endtask
   // Sets the NMI line level.
   task automatic set_nmi(input logic v);
      nmi_pad = v;
   endtask
endmodule

// file: tb_top.sv
// Self-checking testbench for the reset, NMI and power-down pin block.
`timescale 1ns/1ps
module tb_top;
   import rnpc_pkg::*;
   localparam int SEQ = 4;
   logic       clk, rst, sw, wdt, eoi, pdi, wr, wdata;
   logic       pad, nmi, o, oe, ind_n, bden, core, trap, pd;
   logic [1:0] src;
   int         failures, samples_checked;
   rnpc_top #(.SEQ_CYCLES(SEQ)) u_rnpc_top (.CLK_SYS(clk), .RESET(rst),
      .RESET_REQUEST_PIN_I(pad), .RESET_REQUEST_PIN_O(o), .RESET_REQUEST_PIN_OE(oe),
      .RESET_INDICATION_OUT_N(ind_n), .NMI_PIN(nmi), .SW_RESET_REQ(sw),
      .WATCHDOG_TIMER_RESET(wdt), .END_OF_INIT_INSTR(eoi), .POWER_DOWN_INSTR(pdi),
      .BIDIR_RESET_ENABLE_WR(wr), .BIDIR_RESET_ENABLE_WDATA(wdata),
      .BIDIR_RESET_ENABLE(bden), .CORE_RESET(core), .NMI_TRAP(trap),
      .POWER_DOWN(pd), .RESET_SOURCE(src));
   rnpc_board u_rnpc_board (.dev_oe(oe), .dev_o(o), .pad(pad), .nmi_pad(nmi));
   // Free-running 50 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic summarize;
      if (failures == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Waits a bounded time for the core reset to reach a level.
   task automatic wait_core(input logic v);
      for (int i = 0; i < 40 && core !== v; i++) tick(1);
      chk("core_wait", {1'b0, v}, {1'b0, core});
      if (core !== v) summarize();
   endtask
   task automatic eoi_pulse;
      eoi = 1'b1;
      tick(1);
      eoi = 1'b0;
      tick(1);
   endtask
   task automatic t_power_up;
      chk("ind", 2'h0, {1'b0, ind_n});
      chk("bden", 2'h0, {1'b0, bden});
      chk("pd", 2'h0, {1'b0, pd});
      wait_core(1'b0);
   endtask
   task automatic t_init_lock;
      wr = 1'b1;
      wdata = 1'b1;
      tick(1);
      wr = 1'b0;
      chk("bden", 2'h1, {1'b0, bden});
      tick(3);
      chk("ind", 2'h0, {1'b0, ind_n});
      eoi_pulse;
      chk("ind", 2'h1, {1'b0, ind_n});
      wr = 1'b1;
      wdata = 1'b0;
      tick(1);
      wr = 1'b0;
      chk("bden", 2'h1, {1'b0, bden});
   endtask
   task automatic t_bidir;
      sw = 1'b1;
      tick(1);
      sw = 1'b0;
      chk("pad", 2'h0, {1'b0, pad});
      chk("src", SRC_HW_LONG, src);
      chk("bden", 2'h0, {1'b0, bden});
      wait_core(1'b0);
      chk("oe", 2'h0, {1'b0, oe});
      tick(12);
      chk("core", 2'h0, {1'b0, core});
      eoi_pulse;
   endtask
   task automatic t_sources;
      for (int k = 0; k < 2; k++)
      begin
         wdt = (k == 0);
         sw = (k == 1);
         tick(1);
         wdt = 1'b0;
         sw = 1'b0;
         chk("src", (k == 0) ? SRC_WATCHDOG : SRC_SW, src);
         chk("ind", 2'h0, {oe, ind_n});
         wait_core(1'b0);
      end
      eoi_pulse;
   endtask
   task automatic t_pad;
      // Short spike straddles a rising edge so the synchroniser does see it.
      #5;
      u_rnpc_board.hold_low(8);
      tick(12);
      chk("core", 2'h0, {1'b0, core});
      u_rnpc_board.hold_low(140);
      wait_core(1'b1);
      chk("src", SRC_HW_LONG, src);
      wait_core(1'b0);
      eoi_pulse;
      // Recommended long external reset; core must stay in reset throughout.
      u_rnpc_board.hold_low(1_000_000);
      chk("core", 2'h1, {1'b0, core});
      wait_core(1'b0);
      eoi_pulse;
   endtask
   task automatic t_nmi_pd;
      int n;
      n = 0;
      pdi = 1'b1;
      tick(1);
      pdi = 1'b0;
      chk("pd", 2'h0, {core, pd});
      u_rnpc_board.set_nmi(1'b0);
      for (int i = 0; i < 8; i++)
      begin
         tick(1);
         n += (trap === 1'b1);
      end
      chk("trap", 2'h1, n[1:0]);
      pdi = 1'b1;
      tick(1);
      pdi = 1'b0;
      chk("pd", 2'h1, {1'b0, pd});
      u_rnpc_board.set_nmi(1'b1);
      tick(2);
   endtask
   // Main sequence: reset for 20 cycles, then every scenario.
   initial
   begin
      failures = 0;
      samples_checked = 0;
      {rst, sw, wdt, eoi, pdi, wr, wdata} = 7'h40;
      tick(20);
      rst = 1'b0;
      tick(1);
      t_power_up;
      t_init_lock;
      t_bidir;
      t_sources;
      t_pad;
      t_nmi_pd;
      summarize;
   end
endmodule
